// ### hdl/timer_gate_map.svh
// Register offsets, field positions and reset values of the timer gate control block.
`ifndef TIMER_GATE_MAP_SVH
`define TIMER_GATE_MAP_SVH
// Printed offsets are not all multiples of four: they are indexes, byte address is four times.
`define TG_IDX_CTRL_A      12'h20F
`define TG_IDX_CTRL_B      12'h215
`define TG_IDX_CTRL_C      12'h21B
`define TG_IDX_IRQ_STATUS  12'h220
`define TG_IDX_IRQ_MASK    12'h221
`define TG_IDX_TIMER_ON    12'h222
`define TG_BIT_ENABLE      7
`define TG_BIT_POLARITY    6
`define TG_BIT_TOGGLE      5
`define TG_BIT_SINGLE      4
`define TG_BIT_ACQUIRE     3
`define TG_BIT_LEVEL       2
`define TG_CTRL_RESET      8'h00
`define TG_WRITE_MASK      8'hF8
`endif

// ### hdl/timer_gate_pkg.sv
// Types shared by the timer gate control block.
package timer_gate_pkg;
  typedef struct packed {
    logic enable;
    logic polarity;
    logic toggle;
    logic single;
  } gate_cfg_s;
  typedef struct packed {
    logic count_en;
    logic level;
    logic done;
  } gate_out_s;
endpackage

// ### hdl/gate_channel.sv
// One timer's gate path: polarity, toggle flip-flop and single-pulse acquisition.
`include "timer_gate_map.svh"
module gate_channel (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    timer_on,
  input  wire logic                    gate_in,
  input  wire timer_gate_pkg::gate_cfg_s cfg,
  input  wire logic                    acquire_set,
  output logic                         acquire_q,
  output timer_gate_pkg::gate_out_s    gout
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic toggle_q;
  logic seen_q;
  logic pol_gate;
  logic rise;
  logic path;
  logic active;
  logic done_pulse;

  // The gate comes from a pin, so it passes two flops before any logic looks at it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= gate_in;
      sync2_q <= sync1_q;
      prev_q  <= pol_gate;
    end
  end

  // Polarity applied first, so toggle and edge logic work on the active level.
  assign pol_gate = cfg.polarity ? sync2_q : ~sync2_q;
  assign rise     = pol_gate & ~prev_q;

  // Toggle flip-flop flips on each rising active edge and is held clear outside toggle mode.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      toggle_q <= 1'b0;
    end else if (!cfg.toggle) begin
      toggle_q <= 1'b0;
    end else if (rise) begin
      toggle_q <= ~toggle_q;
    end
  end

  assign path = cfg.toggle ? toggle_q : pol_gate;

  // Single pulse: once armed, wait for the path to go active, count through it, then done.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seen_q <= 1'b0;
    end else if (!cfg.single || !acquire_q) begin
      seen_q <= 1'b0;
    end else if (path) begin
      seen_q <= 1'b1;
    end
  end

  assign done_pulse = cfg.single & acquire_q & seen_q & ~path;

  // Software arm wins, since the arming write sets the mode bit in the same edge.
  // Otherwise a cleared mode bit clears the flag, and completion clears it too.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acquire_q <= 1'b0;
    end else if (acquire_set) begin
      acquire_q <= 1'b1;
    end else if (!cfg.single) begin
      acquire_q <= 1'b0;
    end else if (done_pulse) begin
      acquire_q <= 1'b0;
    end
  end

  assign active = cfg.single ? (path & acquire_q) : path;

  assign gout.level    = active;
  assign gout.count_en = timer_on & (cfg.enable ? active : 1'b1);
  assign gout.done     = done_pulse;

  AST_TOGGLE_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg.toggle |=> !toggle_q) else $error("toggle flop not cleared");
  AST_SINGLE_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg.single && !acquire_set) |=> !acquire_q)
    else $error("acquire flag kept without mode");
  AST_POLARITY: assert property (@(posedge clk) disable iff (!rst_n)
    (timer_on && cfg.enable && !cfg.toggle && !cfg.single)
      |-> gout.count_en == (cfg.polarity == sync2_q)) else $error("polarity wrong");
  AST_DONE_DROPS: assert property (@(posedge clk) disable iff (!rst_n)
    (done_pulse && !acquire_set) |=> !acquire_q) else $error("done not cleared");
endmodule // gate_channel

// ### hdl/timer_gate_control.sv
// Three timer gate control registers behind an APB slave, with interrupt on completion.
`include "timer_gate_map.svh"
module timer_gate_control #(
  parameter int N = 3
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [15:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  input  wire logic [N-1:0]  gate_in,
  output logic [N-1:0]       count_en,
  output logic               irq
);
  timer_gate_pkg::gate_cfg_s cfg_q [N];
  timer_gate_pkg::gate_out_s gout [N];
  logic [N-1:0] acquire;
  logic [N-1:0] arm;
  logic [N-1:0] done;
  logic [N-1:0] sel;
  logic [N-1:0] status_q;
  logic [N-1:0] mask_q;
  logic [N-1:0] timer_on_q;
  logic [11:0]  idx;
  logic         wr;
  logic         hit;
  logic [31:0]  rd_d;
  logic [11:0]  ctrl_idx [3];

  assign ctrl_idx[0] = `TG_IDX_CTRL_A;
  assign ctrl_idx[1] = `TG_IDX_CTRL_B;
  assign ctrl_idx[2] = `TG_IDX_CTRL_C;

  // Zero wait states keep the slave simple; every access ends in its first access cycle.
  assign pready = 1'b1;
  assign idx    = paddr[13:2];
  assign wr     = psel & penable & pwrite;

  // Control register decode, one instance per timer.
  always_comb begin
    for (int i = 0; i < N; i++) begin
      sel[i] = (idx == ctrl_idx[i]);
    end
  end

  assign hit = (|sel) || idx == `TG_IDX_IRQ_STATUS || idx == `TG_IDX_IRQ_MASK
               || idx == `TG_IDX_TIMER_ON;

  // Writable control bits; the level bit is not stored so writes cannot touch it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        cfg_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (wr && sel[i]) begin
          cfg_q[i].enable   <= pwdata[`TG_BIT_ENABLE];
          cfg_q[i].polarity <= pwdata[`TG_BIT_POLARITY];
          cfg_q[i].toggle   <= pwdata[`TG_BIT_TOGGLE];
          cfg_q[i].single   <= pwdata[`TG_BIT_SINGLE];
        end
      end
    end
  end

  // Arming needs the single bit set in the written data itself, so mode and flag are set in one write.
  always_comb begin
    for (int i = 0; i < N; i++) begin
      arm[i] = wr & sel[i] & pwdata[`TG_BIT_ACQUIRE] & pwdata[`TG_BIT_SINGLE];
    end
  end

  // Timer on bits stand in for the counters' own switch, which lives outside this block.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_on_q <= '0;
    end else if (wr && idx == `TG_IDX_TIMER_ON) begin
      timer_on_q <= pwdata[N-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_q <= '0;
    end else if (wr && idx == `TG_IDX_IRQ_MASK) begin
      mask_q <= pwdata[N-1:0];
    end
  end

  // Completion sets a sticky bit; a new event in the clearing cycle wins over the clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= '0;
    end else if (wr && idx == `TG_IDX_IRQ_STATUS) begin
      status_q <= (status_q & ~pwdata[N-1:0]) | done;
    end else begin
      status_q <= status_q | done;
    end
  end

  assign irq = |(status_q & mask_q);

  generate
    for (genvar g = 0; g < N; g++) begin : g_ch
      gate_channel u_ch (
        .clk         (clk),
        .rst_n       (rst_n),
        .timer_on    (timer_on_q[g]),
        .gate_in     (gate_in[g]),
        .cfg         (cfg_q[g]),
        .acquire_set (arm[g]),
        .acquire_q   (acquire[g]),
        .gout        (gout[g])
      );
      assign count_en[g] = gout[g].count_en;
      assign done[g]     = gout[g].done;
    end
  endgenerate

  // Read mux; unused bits read zero.
  always_comb begin
    rd_d = '0;
    for (int i = 0; i < N; i++) begin
      if (sel[i]) begin
        rd_d[`TG_BIT_ENABLE]   = cfg_q[i].enable;
        rd_d[`TG_BIT_POLARITY] = cfg_q[i].polarity;
        rd_d[`TG_BIT_TOGGLE]   = cfg_q[i].toggle;
        rd_d[`TG_BIT_SINGLE]   = cfg_q[i].single;
        rd_d[`TG_BIT_ACQUIRE]  = acquire[i];
        rd_d[`TG_BIT_LEVEL]    = gout[i].level;
      end
    end
    if (idx == `TG_IDX_IRQ_STATUS) begin
      rd_d[N-1:0] = status_q;
    end
    if (idx == `TG_IDX_IRQ_MASK) begin
      rd_d[N-1:0] = mask_q;
    end
    if (idx == `TG_IDX_TIMER_ON) begin
      rd_d[N-1:0] = timer_on_q;
    end
  end

  // Read data and error come from flops, loaded in the setup cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_d;
      pslverr <= ~hit;
    end
  end

  AST_OFF_NO_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
    !timer_on_q[0] |-> !count_en[0]) else $error("counting while timer off");
  AST_UNGATED: assert property (@(posedge clk) disable iff (!rst_n)
    (timer_on_q[0] && !cfg_q[0].enable) |-> count_en[0]) else $error("ungated stall");
  AST_ARM_SETS: assert property (@(posedge clk) disable iff (!rst_n)
    arm[0] |=> acquire[0]) else $error("arming lost");
  AST_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    done[0] |=> status_q[0]) else $error("event lost");
  AST_LEVEL_GATES: assert property (@(posedge clk) disable iff (!rst_n)
    (timer_on_q[1] && cfg_q[1].enable) |-> count_en[1] == gout[1].level)
    else $error("gated count differs from level");
endmodule // timer_gate_control

// ### tb/gate_source.sv
// Far-side model of the three raw timer gate pins.
module gate_source (
  input  wire logic       clk,
  input  wire logic [2:0] want,
  output logic [2:0]      gate_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] level_q = 3'h0;
  // The pins are asynchronous to the block, but moving them on our edge keeps the run repeatable.
  always @(posedge clk) begin
    level_q <= want;
  end
  assign gate_in = level_q;
endmodule // gate_source

// ### tb/timer_gate_control_tb.sv
// Self-checking testbench of the timer gate control block.
`include "timer_gate_map.svh"
module timer_gate_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, irq, er;
  logic [2:0]  want = 3'h0, gate_in, count_en;
  int          n_fail = 0, checks = 0;
  always #4 clk = ~clk;
  gate_source u_gate_source (.clk(clk), .want(want), .gate_in(gate_in));
  timer_gate_control #(.N(3)) u_timer_gate_control (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .gate_in(gate_in), .count_en(count_en), .irq(irq));
  // Compare one observed value with its expectation and count the comparison.
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; read data and error are taken only at the edge where pready is high.
  task apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (i >= 16) n_fail++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Outputs are looked at mid-cycle, once the access edge's updates have settled.
    @(negedge clk);
  endtask
  // Move one gate pin and let it pass the pin register and the two sync flops.
  task gate(input int n, input logic v);
    @(posedge clk);
    want[n] <= v;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic [11:0] ctl(input int n);
    return n == 0 ? `TG_IDX_CTRL_A : (n == 1 ? `TG_IDX_CTRL_B : `TG_IDX_CTRL_C);
  endfunction
  // Reset contents, timer off, and an unmapped index.
  task t_reset();
    for (int n = 0; n < 3; n++) begin
      apb(1'b0, ctl(n), 32'h0);
      chk("ctrl reset", rd & 32'hF8, 32'h0);
    end
    apb(1'b1, ctl(0), 32'h80);
    gate(0, 1'b1);
    chk("count off", {29'h0, count_en}, 32'h0);
    apb(1'b0, 12'h230, 32'h0);
    chk("slverr", {31'h0, er}, 32'h1);
    chk("unmapped rd", rd, 32'h0);
  endtask
  // Gating disabled: counting ignores the gate once the timer is on.
  task t_free();
    apb(1'b1, `TG_IDX_TIMER_ON, 32'h7);
    apb(1'b1, ctl(0), 32'h00);
    chk("free hi", {31'h0, count_en[0]}, 32'h1);
    gate(0, 1'b0);
    chk("free lo", {31'h0, count_en[0]}, 32'h1);
  endtask
  // Both polarities on every channel; the level bit follows the gate and ignores writes.
  task t_pol();
    for (int n = 0; n < 3; n++) begin
      apb(1'b1, ctl(n), 32'hC0);
      gate(n, 1'b1);
      chk("pol hi", {31'h0, count_en[n]}, 32'h1);
      apb(1'b0, ctl(n), 32'h0);
      chk("level", {31'h0, rd[2]}, 32'h1);
      gate(n, 1'b0);
      chk("pol hi idle", {31'h0, count_en[n]}, 32'h0);
      gate(n, 1'b1);
      apb(1'b1, ctl(n), 32'h84);
      chk("pol lo idle", {31'h0, count_en[n]}, 32'h0);
      apb(1'b0, ctl(n), 32'h0);
      chk("level ro", rd & 32'hFC, 32'h80);
      gate(n, 1'b0);
      chk("pol lo", {31'h0, count_en[n]}, 32'h1);
    end
  endtask
  // Toggle mode counts over a whole gate period; leaving it clears the flop.
  task t_toggle();
    apb(1'b1, ctl(0), 32'hE0);
    chk("tgl start", {31'h0, count_en[0]}, 32'h0);
    gate(0, 1'b1);
    gate(0, 1'b0);
    chk("tgl set", {31'h0, count_en[0]}, 32'h1);
    gate(0, 1'b1);
    chk("tgl clr", {31'h0, count_en[0]}, 32'h0);
    gate(0, 1'b0);
    gate(0, 1'b1);
    apb(1'b1, ctl(0), 32'hC0);
    gate(0, 1'b0);
    apb(1'b1, ctl(0), 32'hE0);
    chk("tgl cleared", {31'h0, count_en[0]}, 32'h0);
  endtask
  // One armed pulse, completion interrupt with mask and clear, then disarm by software.
  task t_single();
    apb(1'b1, `TG_IDX_IRQ_MASK, 32'h1);
    apb(1'b1, ctl(0), 32'hD8);
    apb(1'b0, ctl(0), 32'h0);
    chk("armed", {31'h0, rd[3]}, 32'h1);
    gate(0, 1'b1);
    chk("pulse count", {31'h0, count_en[0]}, 32'h1);
    gate(0, 1'b0);
    apb(1'b0, ctl(0), 32'h0);
    chk("done", {31'h0, rd[3]}, 32'h0);
    chk("irq set", {31'h0, irq}, 32'h1);
    gate(0, 1'b1);
    chk("no second", {31'h0, count_en[0]}, 32'h0);
    apb(1'b1, `TG_IDX_IRQ_MASK, 32'h0);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, `TG_IDX_IRQ_MASK, 32'h1);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    apb(1'b1, `TG_IDX_IRQ_STATUS, 32'h1);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b1, ctl(0), 32'hD8);
    apb(1'b1, ctl(0), 32'hC0);
    apb(1'b0, ctl(0), 32'h0);
    chk("flag auto clr", {31'h0, rd[3]}, 32'h0);
  endtask
  // Print the counts and the verdict, then stop.
  task end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // The whole sequence needs well under two thousand cycles.
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_free();
    t_pol();
    t_toggle();
    t_single();
    end_sim();
  end
endmodule // timer_gate_control_tb
